// ---- verilog/ecmc_mode_ctrl.sv ----
// mode control of a voice echo canceler with axi4-lite register access
// What this block does
// - center clip forces low tx output to minimum
// - through mode passes data, clears coefficients
// - coefficient hold freezes adaptive filter updates
// - role select low master, high slave
// - rx-only signal attenuates transmit output
// - otherwise attenuate receive input path
// - exactly one attenuator active while enabled, none when disabled, 6 dB
// - atten control low enables, high disables
// - sample controls on frame fall, reset release
// - frame interrupt falling edge starts cycle
// - ignore frame interrupt 100 us after reset
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`include "ecmc_defs.svh"
module ecmc_mode_ctrl
  import ecmc_pkg::*;
#(
  parameter int INIT_CYCLES = `ECMC_INIT_CYCLES
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  // mode pins
  input  wire logic        center_clip_ctrl_i,
  input  wire logic        through_mode_ctrl_i,
  input  wire logic        coef_hold_ctrl_i,
  input  wire logic        atten_ctrl_i,
  input  wire logic        cascade_role_sel_i,
  input  wire logic        frame_int_n_i,
  // signal detect and level from the datapath
  input  wire logic        tx_in_active_i,
  input  wire logic        rx_in_active_i,
  input  wire logic        tx_below_clip_i,
  // mode outputs to the datapath
  output logic             clip_force_min_o,
  output logic             through_mode_o,
  output logic             coef_clear_o,
  output logic             coef_update_en_o,
  output logic             slave_mode_o,
  output logic             tx_att_en_o,
  output logic             rx_att_en_o,
  output logic             frame_start_o,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // mode sampling and frame timing
  ecmc_state_type state_reg,     state_next;
  logic [31:0]    init_cnt_reg,  init_cnt_next;
  logic           int_d_reg,     int_d_next;
  logic           armed_reg,     armed_next;
  logic [3:0]     mode_reg,      mode_next;
  logic           slave_reg,     slave_next;
  logic [7:0]     frame_cnt_reg, frame_cnt_next;
  logic [31:0]    ctrl_reg,      ctrl_next;
  logic           int_fall;
  logic [3:0]     pin_mode;

  // outputs
  logic clip_next, thru_next, clr_next, upd_next;
  logic txa_next, rxa_next, fs_next;

  // axi state
  logic        awhave_reg, awhave_next;
  logic        whave_reg,  whave_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg,  wdata_next;
  logic [3:0]  wstrb_reg,  wstrb_next;
  logic        bvalid_next, arready_next, rvalid_next;
  logic [1:0]  bresp_next,  rresp_next;
  logic [31:0] rdata_next;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign int_fall = int_d_reg & ~frame_int_n_i;
  // software override stands in for the clip, through, hold and atten pins when the override bit is set; role select stays on its pin
  assign pin_mode = ctrl_reg[`ECMC_CTRL_OVR_BIT] ?
                    ctrl_reg[3:0] :
                    {atten_ctrl_i, coef_hold_ctrl_i,
                     through_mode_ctrl_i, center_clip_ctrl_i};

  always_comb begin
    state_next     = state_reg;
    init_cnt_next  = init_cnt_reg;
    int_d_next     = frame_int_n_i;
    armed_next     = armed_reg;
    mode_next      = mode_reg;
    slave_next     = slave_reg;
    frame_cnt_next = frame_cnt_reg;
    fs_next        = 1'b0;
    case (state_reg)
      ECMC_INIT: begin
        if (!armed_reg) begin
          // first clock after reset release stands for its rising edge
          mode_next  = pin_mode;
          slave_next = cascade_role_sel_i;
          armed_next = 1'b1;
        end
        if (init_cnt_reg >= 32'(INIT_CYCLES - 1)) begin
          state_next = ECMC_RUN;
        end else begin
          init_cnt_next = init_cnt_reg + 32'h1;
        end
      end
      ECMC_RUN: begin
        if (int_fall) begin
          mode_next      = pin_mode;
          slave_next     = cascade_role_sel_i;
          fs_next        = 1'b1;
          frame_cnt_next = frame_cnt_reg + 8'h01;
        end
      end
      default: state_next = ECMC_INIT;
    endcase

    clip_next = mode_reg[0] & tx_below_clip_i;
    thru_next = mode_reg[1];
    clr_next  = mode_reg[1];
    upd_next  = ~mode_reg[1] & ~mode_reg[2];
    // low on the atten control enables; one path attenuated only while enabled
    txa_next  = ~mode_reg[3] & rx_in_active_i & ~tx_in_active_i;
    rxa_next  = ~mode_reg[3] & ~txa_next;
  end

  // axi4-lite: write address and data taken in either order
  always_comb begin
    awhave_next  = awhave_reg;
    whave_next   = whave_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    ctrl_next    = ctrl_reg;
    arready_next = 1'b0;
    rvalid_next  = s_axi_rvalid;
    rresp_next   = s_axi_rresp;
    rdata_next   = s_axi_rdata;
    if (s_axi_awvalid && !awhave_reg) begin
      awhave_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !whave_reg) begin
      whave_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (awhave_reg && whave_reg && !s_axi_bvalid) begin
      awhave_next = 1'b0;
      whave_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      if (awaddr_reg[7:2] == 6'(`ECMC_CTRL_OFS >> 2)) begin
        ctrl_next = merge_bytes(ctrl_reg, wdata_reg, wstrb_reg) &
                    32'h0000_001F;
      end else if (awaddr_reg[7:2] != 6'(`ECMC_STATUS_OFS >> 2) &&
                   awaddr_reg[7:2] != 6'(`ECMC_LEVEL_OFS >> 2)) begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      arready_next = 1'b1;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      case (s_axi_araddr[7:2])
        6'(`ECMC_CTRL_OFS >> 2):   rdata_next = ctrl_reg;
        6'(`ECMC_STATUS_OFS >> 2): begin
          rdata_next = 32'h0;
          rdata_next[3:0] = mode_reg;
          rdata_next[`ECMC_ST_ATTEN_BIT] = ~mode_reg[3];
          rdata_next[`ECMC_ST_SLAVE_BIT] = slave_reg;
          rdata_next[`ECMC_ST_TXATT_BIT] = tx_att_en_o;
          rdata_next[`ECMC_ST_RXATT_BIT] = rx_att_en_o;
          rdata_next[`ECMC_ST_READY_BIT] = (state_reg == ECMC_RUN);
          rdata_next[`ECMC_ST_FRAME_LSB +: 8] = frame_cnt_reg;
        end
        6'(`ECMC_LEVEL_OFS >> 2):
          rdata_next = {16'h0, `ECMC_CLIP_MIN, `ECMC_ATTEN_DB};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ECMC_INIT;      init_cnt_reg <= 32'h0;
      int_d_reg <= 1'b1;           armed_reg <= 1'b0;
      mode_reg <= 4'h0;            slave_reg <= 1'b0;
      frame_cnt_reg <= 8'h00;      ctrl_reg <= `ECMC_CTRL_RST_VAL;
      clip_force_min_o <= 1'b0;    through_mode_o <= 1'b0;
      coef_clear_o <= 1'b0;        coef_update_en_o <= 1'b0;
      slave_mode_o <= 1'b0;        tx_att_en_o <= 1'b0;
      rx_att_en_o <= 1'b0;         frame_start_o <= 1'b0;
      awhave_reg <= 1'b0;          whave_reg <= 1'b0;
      awaddr_reg <= 8'h00;         wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;           s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;        s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;        s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      s_axi_awready <= 1'b1;       s_axi_wready <= 1'b1;
    end else if (clk_en_i) begin
      state_reg <= state_next;     init_cnt_reg <= init_cnt_next;
      int_d_reg <= int_d_next;     armed_reg <= armed_next;
      mode_reg <= mode_next;       slave_reg <= slave_next;
      frame_cnt_reg <= frame_cnt_next;
      ctrl_reg <= ctrl_next;
      clip_force_min_o <= clip_next;
      through_mode_o <= thru_next;
      coef_clear_o <= clr_next;
      coef_update_en_o <= upd_next;
      slave_mode_o <= slave_reg;
      tx_att_en_o <= txa_next;
      rx_att_en_o <= rxa_next;
      frame_start_o <= fs_next;
      awhave_reg <= awhave_next;   whave_reg <= whave_next;
      awaddr_reg <= awaddr_next;   wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;     s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;   s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next; s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
      // ready while not holding a word; a held word waits for the response
      s_axi_awready <= ~awhave_next;
      s_axi_wready <= ~whave_next;
    end
  end

endmodule

// ---- shared/ecmc_defs.svh ----
// constants of the echo canceler mode control block
`ifndef ECMC_DEFS_SVH
`define ECMC_DEFS_SVH

// axi4-lite register byte offsets
`define ECMC_CTRL_OFS      8'h00
`define ECMC_STATUS_OFS    8'h04
`define ECMC_LEVEL_OFS     8'h08

// control register fields (pin mirror when sw_override set)
`define ECMC_CTRL_CLIP_BIT    0
`define ECMC_CTRL_THRU_BIT    1
`define ECMC_CTRL_HOLD_BIT    2
`define ECMC_CTRL_ATTOFF_BIT  3
`define ECMC_CTRL_OVR_BIT     4
`define ECMC_CTRL_RST_VAL     32'h0000_0000

// status register fields
`define ECMC_ST_CLIP_BIT    0
`define ECMC_ST_THRU_BIT    1
`define ECMC_ST_HOLD_BIT    2
`define ECMC_ST_ATTEN_BIT   3
`define ECMC_ST_SLAVE_BIT   4
`define ECMC_ST_TXATT_BIT   5
`define ECMC_ST_RXATT_BIT   6
`define ECMC_ST_READY_BIT   7
`define ECMC_ST_FRAME_LSB   8

// timing
`define ECMC_CLK_MHZ        100
`define ECMC_INIT_US        100
`define ECMC_INIT_CYCLES    (`ECMC_INIT_US * `ECMC_CLK_MHZ)

// attenuation figure in db and minimum code for clipped output
`define ECMC_ATTEN_DB       8'h06
`define ECMC_CLIP_MIN       8'h00

`endif

// ---- shared/ecmc_pkg.sv ----
// types of the echo canceler mode control block
package ecmc_pkg;
  typedef enum logic [1:0] {
    ECMC_INIT  = 2'b00,
    ECMC_RUN   = 2'b01
  } ecmc_state_type;

  typedef enum logic [1:0] {
    ECMC_ATT_NONE = 2'b00,
    ECMC_ATT_TX   = 2'b01,
    ECMC_ATT_RX   = 2'b10
  } ecmc_att_type;
endpackage

// ---- dv/ecmc_mode_ctrl_properties.sv ----
// assertions on the ports of the mode control block
module ecmc_mode_ctrl_properties #(
  parameter int INIT_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic frame_int_n_i,
  input wire logic center_clip_ctrl_i,
  input wire logic through_mode_ctrl_i,
  input wire logic coef_hold_ctrl_i,
  input wire logic atten_ctrl_i,
  input wire logic cascade_role_sel_i,
  input wire logic tx_in_active_i,
  input wire logic rx_in_active_i,
  input wire logic tx_below_clip_i,
  input wire logic frame_start_o,
  input wire logic through_mode_o,
  input wire logic coef_clear_o,
  input wire logic coef_update_en_o,
  input wire logic slave_mode_o,
  input wire logic clip_force_min_o,
  input wire logic tx_att_en_o,
  input wire logic rx_att_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned age_reg;
  logic        en_d_reg;
  default clocking @(posedge clk_i); endclocking
  // a frozen edge and the one after it break every one-cycle relation
  default disable iff (sys_rst_i || !clk_en_i || !en_d_reg);
  // edges since reset release, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    en_d_reg <= clk_en_i;
    if (sys_rst_i) age_reg <= 0;
    else if (age_reg < INIT_CYCLES + 8) age_reg <= age_reg + 1;
  end
  a_frame_start: assert property (age_reg > INIT_CYCLES + 2 &&
    $fell(frame_int_n_i) |=> frame_start_o) else $error("frame lost");
  a_no_spurious: assert property (!$fell(frame_int_n_i)
    |=> !frame_start_o) else $error("start pulse without frame fall");
  a_init_ignore: assert property (age_reg + 3 < INIT_CYCLES
    |=> !frame_start_o) else $error("frame taken during init");
  a_mode_capture: assert property (frame_start_o |=>
    through_mode_o == $past(through_mode_ctrl_i, 2) &&
    coef_clear_o == through_mode_o &&
    slave_mode_o == $past(cascade_role_sel_i, 2))
    else $error("mode not captured");
  a_coef_update: assert property (frame_start_o |=>
    coef_update_en_o == !($past(through_mode_ctrl_i, 2) ||
    $past(coef_hold_ctrl_i, 2))) else $error("coefficient update");
  a_mode_hold: assert property (age_reg > 4 && !frame_start_o
    |=> $stable(through_mode_o) && $stable(coef_update_en_o) &&
    $stable(slave_mode_o)) else $error("mode moved between frames");
  a_clip_force: assert property (frame_start_o && tx_below_clip_i
    |=> clip_force_min_o == $past(center_clip_ctrl_i, 2))
    else $error("clip mode wrong");
  a_clip_cause: assert property (!tx_below_clip_i
    |=> !clip_force_min_o) else $error("clip on loud signal");
  a_att_enable: assert property (frame_start_o |=>
    (tx_att_en_o || rx_att_en_o) == !$past(atten_ctrl_i, 2))
    else $error("attenuator enable wrong");
  a_att_single: assert property (!(tx_att_en_o && rx_att_en_o))
    else $error("both attenuators on");
  a_att_route: assert property (tx_att_en_o || rx_att_en_o
    |-> tx_att_en_o == ($past(rx_in_active_i) && !$past(tx_in_active_i)))
    else $error("attenuator path wrong");
endmodule

bind ecmc_mode_ctrl ecmc_mode_ctrl_properties #(
  .INIT_CYCLES(INIT_CYCLES)
) i_ecmc_mode_ctrl_properties (
  .clk_i, .sys_rst_i, .clk_en_i, .frame_int_n_i, .center_clip_ctrl_i,
  .through_mode_ctrl_i, .coef_hold_ctrl_i, .atten_ctrl_i,
  .cascade_role_sel_i, .tx_in_active_i, .rx_in_active_i,
  .tx_below_clip_i, .frame_start_o, .through_mode_o, .coef_clear_o,
  .coef_update_en_o, .slave_mode_o, .clip_force_min_o, .tx_att_en_o,
  .rx_att_en_o
);

// ---- dv/ecmc_host_model.sv ----
// host model that sets the mode pins and strikes frame interrupts
module ecmc_host_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // request
  input  wire logic       go_i,
  input  wire logic [3:0] mode_i,
  input  wire logic       slave_i,
  // pins
  output logic            center_clip_ctrl_o,
  output logic            through_mode_ctrl_o,
  output logic            coef_hold_ctrl_o,
  output logic            atten_ctrl_o,
  output logic            cascade_role_sel_o,
  output logic            frame_int_n_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] step_reg;
  assign busy_o = step_reg != 4'h0;
  always_ff @(posedge clk_i) begin
    // pins move only with the frame line idle, long before its fall
    if (sys_rst_i || (go_i && !busy_o)) begin
      center_clip_ctrl_o <= mode_i[0] & ~slave_i;
      through_mode_ctrl_o <= mode_i[1];
      coef_hold_ctrl_o <= mode_i[2] & ~slave_i;
      atten_ctrl_o <= mode_i[3] & ~slave_i;
      cascade_role_sel_o <= slave_i;
      frame_int_n_o <= 1'b1;
      step_reg <= {3'h0, ~sys_rst_i};
    end else if (busy_o) begin
      step_reg <= step_reg + 4'h1;
      frame_int_n_o <= !(step_reg inside {4'h4, 4'h5});
    end
  end
endmodule

// ---- dv/ecmc_mode_ctrl_tb_top.sv ----
// self-checking bench of the echo canceler mode control block
`include "ecmc_defs.svh"
module ecmc_mode_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 20;
  logic clk_i = 0, sys_rst_i = 1, clk_en_i = 1, frame_int_n_i;
  logic center_clip_ctrl_i, through_mode_ctrl_i, coef_hold_ctrl_i;
  logic atten_ctrl_i, cascade_role_sel_i, frame_start_o;
  logic tx_in_active_i = 0, rx_in_active_i = 1, tx_below_clip_i = 1;
  logic clip_force_min_o, through_mode_o, coef_clear_o, coef_update_en_o;
  logic slave_mode_o, tx_att_en_o, rx_att_en_o;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 52826, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF, mode = 4'b0101;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, go = 0, slave = 0, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  int miscompares = 0, check_count = 0;
  always #5 clk_i = ~clk_i;
  ecmc_mode_ctrl #(.INIT_CYCLES(INIT)) i_ecmc_mode_ctrl (
    .clk_i, .sys_rst_i, .clk_en_i, .center_clip_ctrl_i,
    .through_mode_ctrl_i, .coef_hold_ctrl_i, .atten_ctrl_i,
    .cascade_role_sel_i, .frame_int_n_i, .tx_in_active_i, .rx_in_active_i,
    .tx_below_clip_i, .clip_force_min_o, .through_mode_o, .coef_clear_o,
    .coef_update_en_o, .slave_mode_o, .tx_att_en_o, .rx_att_en_o,
    .frame_start_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  ecmc_host_model i_ecmc_host_model (
    .clk_i, .sys_rst_i, .go_i(go), .mode_i(mode), .slave_i(slave),
    .center_clip_ctrl_o(center_clip_ctrl_i),
    .through_mode_ctrl_o(through_mode_ctrl_i),
    .coef_hold_ctrl_o(coef_hold_ctrl_i), .atten_ctrl_o(atten_ctrl_i),
    .cascade_role_sel_o(cascade_role_sel_i),
    .frame_int_n_o(frame_int_n_i), .busy_o(busy));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // outputs in port order, from the pins the host actually drives
  function automatic logic [31:0] expect_out(logic [3:0] m, logic s, t, r, b);
    logic a, h, ta;
    a = ~m[3] | s;
    h = m[2] & ~s;
    ta = a & r & ~t;
    return {25'h0, m[0] & ~s & b, m[1], m[1], ~(m[1] | h), s, ta, a & ~ta};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  // one mode change plus one frame fall, then time for outputs to land
  task automatic frame();
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (busy) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask
  function automatic logic [31:0] outs();
    return {25'h0, clip_force_min_o, through_mode_o, coef_clear_o,
      coef_update_en_o, slave_mode_o, tx_att_en_o, rx_att_en_o};
  endfunction
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(outs(), expect_out(4'b0101, 0, 0, 1, 1));
    mode <= 4'b1010;
    frame();
    check(outs(), expect_out(4'b0101, 0, 0, 1, 1));
    repeat (INIT) @(posedge clk_i);
    rd(`ECMC_STATUS_OFS);
    check(rd_data & 32'h0000_FF80, 32'h0000_0080);
    rd(`ECMC_LEVEL_OFS);
    check(rd_data, 32'h0000_0006);
    rd(8'h0C);
    check(32'(rd_resp), 32'h0000_0002);
    wr(`ECMC_CTRL_OFS, 32'hFFFF_FFEF);
    rd(`ECMC_CTRL_OFS);
    check(rd_data, 32'h0000_000F);
    wr(`ECMC_CTRL_OFS, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      rd_data = xs();
      mode <= rd_data[3:0];
      slave <= rd_data[4];
      tx_in_active_i <= rd_data[5];
      rx_in_active_i <= rd_data[6];
      tx_below_clip_i <= rd_data[7];
      frame();
      check(outs(), expect_out(mode, slave, tx_in_active_i,
        rx_in_active_i, tx_below_clip_i));
    end
    // clock enable low must freeze outputs against moving inputs
    mode <= 4'b0001;
    slave <= 1'b0;
    tx_in_active_i <= 1'b0;
    rx_in_active_i <= 1'b1;
    tx_below_clip_i <= 1'b1;
    frame();
    clk_en_i <= 1'b0;
    tx_in_active_i <= 1'b1;
    rx_in_active_i <= 1'b0;
    tx_below_clip_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(outs(), expect_out(4'b0001, 0, 0, 1, 1));
    clk_en_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(outs(), expect_out(4'b0001, 0, 1, 0, 0));
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
endmodule
